/* File: sim/pmc_cpu_model.sv */
// partner model: cpu core that issues halt and wait instructions on request
module pmc_cpu_model (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic cpu_clk_en_i,
   input wire logic do_halt_i,
   input wire logic do_wait_i,
   output logic halt_o,
   output logic wait_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // a cpu with its clock gated cannot execute, so requests are dropped then
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         halt_o <= 1'b0;
         wait_o <= 1'b0;
      end else begin
         halt_o <= do_halt_i & cpu_clk_en_i;
         wait_o <= do_wait_i & cpu_clk_en_i & ~do_halt_i;
      end
   end
endmodule

/* File: sim/power_mode_controller_bench.sv */
// testbench: power mode controller, scenario tasks against a cpu model
module power_mode_controller_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // short start delay keeps the run brief; expectations derive from it
   localparam int SC = 4;
   logic clk, arst_n, we, re, dh, dw, hi, wi, irq, hwk, rreq, wen, wopt, tbe;
   logic fcpu, osc, cen, pen, tben, imc, wrst, wirq, wrs;
   logic [7:0] addr, wdata, rdata, v;
   int failures, n_checks, cyc, k;

   pmc_power_ctrl #(.START_CYCLES(SC)) uut (.clk_i(clk), .arst_n_i(arst_n),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
      .reg_rdata_o(rdata), .halt_instr_i(hi), .wait_for_interrupt_instr_i(wi),
      .irq_pending_i(irq), .irq_halt_wake_i(hwk), .rst_req_i(rreq),
      .wdg_enabled_i(wen), .watchdog_halt_option_i(wopt), .tb_elapsed_i(tbe),
      .fcpu_o(fcpu), .osc_en_o(osc), .cpu_clk_en_o(cen), .periph_clk_en_o(pen),
      .timebase_clk_en_o(tben), .imask_clr_o(imc), .wdg_reset_o(wrst),
      .wake_irq_o(wirq), .wake_rst_o(wrs));
   pmc_cpu_model cpu (.clk_i(clk), .arst_n_i(arst_n), .cpu_clk_en_i(cen),
      .do_halt_i(dh), .do_wait_i(dw), .halt_o(hi), .wait_o(wi));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // whole run needs a few hundred cycles; ceiling well above that
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         finish_test();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1 check(rdata, exp);
   endtask
   // asks the cpu model for one instruction, returns after the taking edge
   task automatic instr(input logic h);
      @(posedge clk);
      dh <= h;
      dw <= ~h;
      @(posedge clk);
      dh <= 1'b0;
      dw <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rise(output int n);
      logic p, r;
      n = 0;
      p = fcpu;
      r = 1'b0;
      while (!r && n < 100) begin
         @(posedge clk);
         #1;
         n++;
         r = (fcpu === 1'b1) && (p !== 1'b1);
         p = fcpu;
      end
   endtask
   // the second rise may still be the old ratio, so the third is measured
   task automatic period_chk(input logic [7:0] exp);
      rise(k);
      rise(k);
      rise(k);
      check(k[7:0], exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check({osc, cen, pen, tben, imc, wrst, wirq, wrs}, 8'hf0);
      rdchk(pmc_pkg::PSTAT_ADDR, 8'h01);
      rdchk(pmc_pkg::MCCS_ADDR, 8'h01);
      rdchk(pmc_pkg::MCCS_ADDR, 8'h00);
      rdchk(pmc_pkg::MISC1_ADDR, 8'h00);
      rdchk(8'h55, 8'h00);
   endtask
   task automatic t_clock();
      period_chk(8'h02);
      for (int i = 0; i < 4; i++) begin
         wr(pmc_pkg::MISC1_ADDR, 8'h04 | i[7:0]);
         rdchk(pmc_pkg::MISC1_ADDR, 8'h04 | i[7:0]);
         period_chk(8'h04 << i);
      end
      wr(pmc_pkg::MISC1_ADDR, 8'h00);
      period_chk(8'h02);
   endtask
   task automatic t_wait(input logic slow);
      wr(pmc_pkg::MISC1_ADDR, slow ? 8'h05 : 8'h00);
      instr(1'b0);
      check({4'h0, cen, pen, imc, osc}, 8'h07);
      rdchk(pmc_pkg::PSTAT_ADDR, 8'h02);
      if (slow)
         period_chk(8'h08);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      #1 check({4'h0, wirq, wrs, cen, imc}, 8'h0a);
      @(posedge clk);
      irq <= 1'b0;
      #1 check({7'h0, wirq}, 8'h00);
      rdchk(pmc_pkg::MISC1_ADDR, slow ? 8'h05 : 8'h00);
      wr(pmc_pkg::MISC1_ADDR, 8'h00);
   endtask
   // halt entry, a non-waking interrupt, wake by irq, reset or time base
   task automatic t_halt(input logic ae, input logic by_rst);
      wr(pmc_pkg::MCCS_ADDR, {6'h0, ae, 1'b0});
      rdchk(pmc_pkg::MCCS_ADDR, {6'h0, ae, 1'b0});
      instr(1'b1);
      check({6'h0, wrst, imc}, 8'h01);
      check({5'h0, osc, pen, tben}, {5'h0, ae, 1'b0, ae});
      rdchk(pmc_pkg::PSTAT_ADDR, ae ? 8'h08 : 8'h04);
      @(posedge clk);
      irq <= 1'b1;
      repeat (3) @(posedge clk);
      irq <= 1'b0;
      #1 check({6'h0, cen, pen}, 8'h00);
      @(posedge clk);
      rreq <= by_rst;
      hwk <= !by_rst && !ae;
      tbe <= !by_rst && ae;
      @(posedge clk);
      rreq <= 1'b0;
      hwk <= 1'b0;
      tbe <= 1'b0;
      k = 0;
      while (!(wirq === 1'b1 || wrs === 1'b1) && k < 200) begin
         @(posedge clk);
         #1;
         k++;
         if (k == 2)
            check({7'h0, osc}, 8'h01);
      end
      check({6'h0, wirq, wrs}, by_rst ? 8'h01 : 8'h02);
      check({7'h0, k >= SC * 2 && k <= SC * 2 + 6}, 8'h01);
      check({5'h0, cen, pen, osc}, 8'h07);
      rdchk(pmc_pkg::PSTAT_ADDR, 8'h01);
      if (ae && !by_rst)
         rdchk(pmc_pkg::MCCS_ADDR, 8'h03);
   endtask
   task automatic t_wdg();
      wr(pmc_pkg::MCCS_ADDR, 8'h00);
      instr(1'b1);
      check({7'h0, wrst}, 8'h01);
      @(posedge clk);
      #1 check({7'h0, wrst}, 8'h00);
      rdchk(pmc_pkg::PSTAT_ADDR, 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {we, re, dh, dw, irq, hwk, rreq, wen, wopt, tbe} = 10'h000;
      addr = 8'h00;
      wdata = 8'h00;
      arst_n = 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_clock();
      t_wait(1'b0);
      t_wait(1'b1);
      t_halt(1'b0, 1'b0);
      @(posedge clk) wen <= 1'b1;
      wopt <= 1'b1;
      t_halt(1'b0, 1'b1);
      @(posedge clk) wopt <= 1'b0;
      t_halt(1'b1, 1'b0);
      t_wdg();
      finish_test();
   end
endmodule

/* File: src/pmc_clk_div.sv */
// module: glitch-free master clock divider from the oscillator
module pmc_clk_div (
   input wire logic clk_i,
   input wire logic arst_n_i,
   pmc_clk_if.div_mp c
);
   logic [5:0] cnt_q;
   logic [5:0] ratio_q;
   logic fcpu_q;
   logic tick_q;
   logic last;

   assign last = (cnt_q == ratio_q - 6'h01);
   assign c.fcpu = fcpu_q;
   assign c.tick = tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // new ratio taken only at period end or while the oscillator is stopped, so no runt pulse on the clock
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 6'h00;
         ratio_q <= pmc_pkg::NORM_DIV;
      end else if (!c.osc_run) begin
         cnt_q <= 6'h00;
         ratio_q <= c.ratio;
      end else if (last) begin
         cnt_q <= 6'h00;
         ratio_q <= c.ratio; // [R20]
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fcpu_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         fcpu_q <= c.osc_run && (cnt_q < (ratio_q >> 1)); // [R2] [R16]
         tick_q <= c.osc_run && last;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_ratio_stable: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R20]
      (c.osc_run && $past(c.osc_run) && cnt_q != 6'h00) |-> ratio_q == $past(ratio_q))
      else $error("divider ratio changed mid period");
   a_clock_stops: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R7]
      !c.osc_run |=> !fcpu_q && !tick_q)
      else $error("divided clock runs with oscillator off");
endmodule

/* File: src/pmc_clk_if.sv */
// interface: divider and start-delay hookup inside the power mode controller
interface pmc_clk_if;
   logic osc_run;
   logic [5:0] ratio;
   logic fcpu;
   logic tick;
   logic dly_start;
   logic dly_busy;
   logic dly_done;

   modport div_mp (input osc_run, input ratio, output fcpu, output tick);
   modport dly_mp (input tick, input dly_start, output dly_busy, output dly_done);
   modport ctl_mp (output osc_run, output ratio, output dly_start,
      input fcpu, input tick, input dly_busy, input dly_done);
endinterface

/* File: src/pmc_pkg.sv */
// package: constants, state codes and divider decode for the power mode controller
package pmc_pkg;
   // register map
   localparam logic [7:0] MCCS_ADDR = 8'h29;
   localparam logic [7:0] MISC1_ADDR = 8'h20;
   localparam logic [7:0] PSTAT_ADDR = 8'h21;
   // main_clock_ctrl_status fields
   localparam int FLAG_BIT = 0;
   localparam int IRQ_EN_BIT = 1;
   localparam int TB_LSB = 2;
   localparam logic [7:0] MCCS_RST = 8'h01;
   // misc_control_1 fields
   localparam int CP_LSB = 0;
   localparam int SLOW_BIT = 2;
   localparam logic [7:0] MISC1_RST = 8'h00;
   // clock division and wake timing
   localparam int DIV_W = 6;
   localparam logic [5:0] NORM_DIV = 6'h02;
   localparam logic [5:0] SLOW_DIV_BASE = 6'h04;
   localparam int START_DELAY = 4096;

   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_WAIT = 5'h02,
      ST_HALT = 5'h04,
      ST_AHALT = 5'h08,
      ST_START = 5'h10
   } pmc_state_t;

   // oscillator division ratio for the current slow mode settings
   function automatic logic [5:0] div_ratio(input logic slow, input logic [1:0] cp);
      div_ratio = slow ? (SLOW_DIV_BASE << cp) : NORM_DIV;
   endfunction
endpackage

/* File: src/pmc_power_ctrl.sv */
// module: power mode controller top, modes, wake-up and registers
//
// Contract
// [R1] any reset leaves the device in normal run mode
// [R2] run mode master clock is oscillator divided by two
// [R3] halt instruction enters deep halt if osc_interrupt_enable 0, else oscillator-only sleep
// [R4] entering either halt variant forces the interrupt mask bit to zero
// [R5] halt exits on reset or wake-capable interrupt, then waits 4096 cpu cycles
// [R6] after the delay, service the waking interrupt or fetch the reset vector
// [R7] deep halt stops the oscillator and all internal processing
// [R8] halt with enable clear and watchdog on gives watchdog reset, per option
// [R9] deep halt wake restarts oscillator at once, delay used for stabilisation
// [R10] oscillator-only sleep runs only oscillator and its time base counter
// [R11] oscillator-only sleep never produces a watchdog reset
// [R12] wait instruction stops cpu clock, peripherals keep running
// [R13] wait forces interrupt mask to zero, other state unchanged
// [R14] wait lasts until interrupt or reset, then branch to its routine
// [R15] slow mode set by slow_mode_select and two-bit divider select
// [R16] slow mode divides by 4, 8, 16 or 32 for cpu and peripherals
// [R17] wait while slow keeps divided clock for peripherals
// [R18] any interrupt ends wait; only wake-capable ones end halt
// [R19] osc_interrupt_flag set on time base elapse, cleared by status read
// [R20] divider codes 00..11 give 4, 8, 16, 32, switched without glitch
module pmc_power_ctrl #(
   parameter int START_CYCLES = pmc_pkg::START_DELAY
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   input wire logic halt_instr_i,
   input wire logic wait_for_interrupt_instr_i,
   input wire logic irq_pending_i,
   input wire logic irq_halt_wake_i,
   input wire logic rst_req_i,
   input wire logic wdg_enabled_i,
   input wire logic watchdog_halt_option_i,
   input wire logic tb_elapsed_i,
   output logic fcpu_o,
   output logic osc_en_o,
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic timebase_clk_en_o,
   output logic imask_clr_o,
   output logic wdg_reset_o,
   output logic wake_irq_o,
   output logic wake_rst_o
);
   pmc_pkg::pmc_state_t state_q;
   pmc_pkg::pmc_state_t state_d;
   logic [7:0] mccs_q;
   logic [7:0] misc1_q;
   logic cause_rst_q;
   logic dly_start_q;
   logic irq_en;
   logic slow_en;
   logic wdg_kill;
   logic halt_wake;
   logic mccs_rd;

   pmc_clk_if clk ();

   ////////////////////////////////////////////////////////////////////////////
   // divider and start delay
   assign irq_en = mccs_q[pmc_pkg::IRQ_EN_BIT];
   assign slow_en = misc1_q[pmc_pkg::SLOW_BIT];
   assign clk.osc_run = (state_q != pmc_pkg::ST_HALT); // [R7] [R9]
   assign clk.ratio = pmc_pkg::div_ratio(slow_en, misc1_q[pmc_pkg::CP_LSB +: 2]); // [R15] [R16]
   assign clk.dly_start = dly_start_q;
   assign fcpu_o = clk.fcpu;

   pmc_clk_div u_div (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .c(clk.div_mp)
   );

   pmc_start_dly #(.CYCLES(START_CYCLES)) u_dly (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .c(clk.dly_mp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencing
   // the watchdog reset itself is issued outside; the device stays in run
   assign wdg_kill = !irq_en && wdg_enabled_i && !watchdog_halt_option_i; // [R8]
   // deep halt has no oscillator, so only outside wake sources apply
   assign halt_wake = rst_req_i || irq_halt_wake_i ||
      (state_q == pmc_pkg::ST_AHALT && irq_en && mccs_q[pmc_pkg::FLAG_BIT]); // [R18] [R11]

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         pmc_pkg::ST_RUN: begin
            if (halt_instr_i && !wdg_kill) begin
               state_d = irq_en ? pmc_pkg::ST_AHALT : pmc_pkg::ST_HALT; // [R3]
            end else if (wait_for_interrupt_instr_i) begin
               state_d = pmc_pkg::ST_WAIT; // [R12] [R17]
            end
         end
         pmc_pkg::ST_WAIT: begin
            if (rst_req_i || irq_pending_i) begin
               state_d = pmc_pkg::ST_RUN; // [R14] [R18]
            end
         end
         pmc_pkg::ST_HALT, pmc_pkg::ST_AHALT: begin
            if (halt_wake) begin
               state_d = pmc_pkg::ST_START; // [R5] [R9]
            end
         end
         pmc_pkg::ST_START: begin
            if (clk.dly_done) begin
               state_d = pmc_pkg::ST_RUN; // [R6]
            end
         end
         default: state_d = pmc_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= pmc_pkg::ST_RUN; // [R1]
      end else begin
         state_q <= state_d;
      end
   end

   // wake cause is kept so the right vector is taken after the delay
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cause_rst_q <= 1'b0;
         dly_start_q <= 1'b0;
      end else begin
         dly_start_q <= (state_q != pmc_pkg::ST_START) && (state_d == pmc_pkg::ST_START);
         if (state_q != pmc_pkg::ST_START && state_d == pmc_pkg::ST_START) begin
            cause_rst_q <= rst_req_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gating outputs registered from the next state, event outputs from the present state
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         osc_en_o <= 1'b1;
         cpu_clk_en_o <= 1'b1;
         periph_clk_en_o <= 1'b1;
         timebase_clk_en_o <= 1'b1;
         imask_clr_o <= 1'b0;
      end else begin
         osc_en_o <= (state_d != pmc_pkg::ST_HALT); // [R7] [R9]
         cpu_clk_en_o <= (state_d == pmc_pkg::ST_RUN); // [R12]
         periph_clk_en_o <= (state_d == pmc_pkg::ST_RUN) ||
            (state_d == pmc_pkg::ST_WAIT); // [R10] [R12] [R17]
         timebase_clk_en_o <= (state_d != pmc_pkg::ST_HALT); // [R10]
         imask_clr_o <= (state_d == pmc_pkg::ST_WAIT) || (state_d == pmc_pkg::ST_HALT) ||
            (state_d == pmc_pkg::ST_AHALT); // [R4] [R13]
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdg_reset_o <= 1'b0;
         wake_irq_o <= 1'b0;
         wake_rst_o <= 1'b0;
      end else begin
         wdg_reset_o <= (state_q == pmc_pkg::ST_RUN) && halt_instr_i && wdg_kill; // [R8]
         wake_irq_o <= (state_q == pmc_pkg::ST_WAIT && !rst_req_i && irq_pending_i) ||
            (state_q == pmc_pkg::ST_START && clk.dly_done && !cause_rst_q); // [R6] [R14]
         wake_rst_o <= (state_q == pmc_pkg::ST_WAIT && rst_req_i) ||
            (state_q == pmc_pkg::ST_START && clk.dly_done && cause_rst_q); // [R6] [R14]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   assign mccs_rd = reg_re_i && (reg_addr_i == pmc_pkg::MCCS_ADDR);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mccs_q <= pmc_pkg::MCCS_RST;
      end else begin
         if (reg_we_i && reg_addr_i == pmc_pkg::MCCS_ADDR) begin
            mccs_q[pmc_pkg::TB_LSB +: 2] <= reg_wdata_i[pmc_pkg::TB_LSB +: 2];
            mccs_q[pmc_pkg::IRQ_EN_BIT] <= reg_wdata_i[pmc_pkg::IRQ_EN_BIT];
         end
         // a time base event in the read cycle survives the clear
         if (tb_elapsed_i && clk.osc_run) begin
            mccs_q[pmc_pkg::FLAG_BIT] <= 1'b1; // [R19]
         end else if (mccs_rd) begin
            mccs_q[pmc_pkg::FLAG_BIT] <= 1'b0; // [R19]
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         misc1_q <= pmc_pkg::MISC1_RST;
      end else if (reg_we_i && reg_addr_i == pmc_pkg::MISC1_ADDR) begin
         misc1_q <= {5'h00, reg_wdata_i[2:0]}; // [R15]
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_re_i) begin
         unique case (reg_addr_i)
            pmc_pkg::MCCS_ADDR: reg_rdata_o <= mccs_q;
            pmc_pkg::MISC1_ADDR: reg_rdata_o <= misc1_q;
            pmc_pkg::PSTAT_ADDR: reg_rdata_o <= {3'h0, state_q};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_reset_run: assert property ($rose(arst_n_i) |-> state_q == pmc_pkg::ST_RUN) // [R1]
      else $error("not in run after reset");
   a_halt_select: assert property ( // [R3]
      (state_q == pmc_pkg::ST_RUN && halt_instr_i && !wdg_kill) |=>
      state_q == ($past(irq_en) ? pmc_pkg::ST_AHALT : pmc_pkg::ST_HALT))
      else $error("wrong halt variant");
   a_imask_forced: assert property ( // [R4] [R13]
      state_q inside {pmc_pkg::ST_WAIT, pmc_pkg::ST_HALT, pmc_pkg::ST_AHALT} |-> imask_clr_o)
      else $error("interrupt mask not forced clear");
   a_osc_stopped: assert property ( // [R7]
      state_q == pmc_pkg::ST_HALT |-> !osc_en_o && !periph_clk_en_o && !cpu_clk_en_o)
      else $error("clocks running in deep halt");
   a_wdg_reset: assert property ( // [R8]
      (state_q == pmc_pkg::ST_RUN && halt_instr_i && wdg_kill) |=>
      wdg_reset_o && state_q == pmc_pkg::ST_RUN)
      else $error("missing watchdog reset on halt");
   a_sleep_gating: assert property ( // [R10] [R11]
      state_q == pmc_pkg::ST_AHALT |-> osc_en_o && timebase_clk_en_o &&
      !periph_clk_en_o && !wdg_reset_o)
      else $error("bad gating in oscillator-only sleep");
   a_wait_clocks: assert property ( // [R12] [R17]
      state_q == pmc_pkg::ST_WAIT |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o)
      else $error("bad gating in wait");
   a_wait_exit: assert property ( // [R14] [R18]
      (state_q == pmc_pkg::ST_WAIT && irq_pending_i && !rst_req_i) |=>
      state_q == pmc_pkg::ST_RUN && wake_irq_o)
      else $error("wait not left on interrupt");
   a_halt_hold: assert property ( // [R18]
      (state_q == pmc_pkg::ST_HALT && !rst_req_i && !irq_halt_wake_i) |=>
      state_q == pmc_pkg::ST_HALT)
      else $error("deep halt left without wake source");
   a_oif_set: assert property ( // [R19]
      (tb_elapsed_i && state_q != pmc_pkg::ST_HALT) |=> mccs_q[pmc_pkg::FLAG_BIT])
      else $error("time base flag not set");
   a_start_vector: assert property ( // [R5] [R6]
      (state_q == pmc_pkg::ST_START && clk.dly_done) |=>
      state_q == pmc_pkg::ST_RUN && (wake_irq_o != wake_rst_o))
      else $error("no vector after start delay");

   // gating checked against the present state, so a lagging enable shows up
   a_run_clocks: assert property ( // [R1] [R2]
      state_q == pmc_pkg::ST_RUN |-> osc_en_o && cpu_clk_en_o && periph_clk_en_o &&
      timebase_clk_en_o && !imask_clr_o)
      else $error("clocks gated in run");
   a_start_gating: assert property ( // [R9]
      state_q == pmc_pkg::ST_START |-> osc_en_o && timebase_clk_en_o && !cpu_clk_en_o &&
      !periph_clk_en_o && !imask_clr_o)
      else $error("bad gating during start delay");
   a_start_load: assert property ( // [R5] [R9]
      (state_q == pmc_pkg::ST_START && $past(state_q) != pmc_pkg::ST_START) |-> clk.dly_start)
      else $error("start delay not loaded on wake");
   a_start_hold: assert property ( // [R5]
      (state_q == pmc_pkg::ST_START && !clk.dly_done) |=> state_q == pmc_pkg::ST_START)
      else $error("start delay cut short");
   a_wait_hold: assert property ( // [R14]
      (state_q == pmc_pkg::ST_WAIT && !irq_pending_i && !rst_req_i) |=>
      state_q == pmc_pkg::ST_WAIT)
      else $error("wait left without wake source");
   a_sleep_hold: assert property ( // [R18]
      (state_q == pmc_pkg::ST_AHALT && !rst_req_i && !irq_halt_wake_i &&
      !mccs_q[pmc_pkg::FLAG_BIT]) |=> state_q == pmc_pkg::ST_AHALT)
      else $error("sleep left without wake source");
   a_wake_single: assert property ( // [R6] [R14]
      (wake_irq_o || wake_rst_o) |=> !wake_irq_o && !wake_rst_o)
      else $error("wake pulse longer than one cycle");
   a_wake_excl: assert property (!(wake_irq_o && wake_rst_o)) // [R6]
      else $error("both wake vectors requested");
   a_flag_clear: assert property ( // [R19]
      (mccs_rd && !(tb_elapsed_i && clk.osc_run)) |=> !mccs_q[pmc_pkg::FLAG_BIT])
      else $error("time base flag not cleared by read");
   a_norm_ratio: assert property ( // [R2]
      !slow_en |-> clk.ratio == pmc_pkg::NORM_DIV)
      else $error("run ratio not two");
   a_slow_ratio: assert property ( // [R16] [R20]
      slow_en |-> clk.ratio inside {6'h04, 6'h08, 6'h10, 6'h20})
      else $error("slow ratio out of range");
   a_misc_unused: assert property ( // [R15]
      misc1_q[7:3] == 5'h00)
      else $error("unused control bits set");

   c_active_halt: cover property (state_q == pmc_pkg::ST_AHALT ##1 state_q == pmc_pkg::ST_START);
   c_halt_wake: cover property (state_q == pmc_pkg::ST_START ##1 wake_rst_o);
   c_slow_wait: cover property (state_q == pmc_pkg::ST_WAIT && slow_en);
   c_deep_wake: cover property (state_q == pmc_pkg::ST_HALT ##1 state_q == pmc_pkg::ST_START);
   c_wait_exit: cover property (state_q == pmc_pkg::ST_WAIT ##1 wake_irq_o);
endmodule

/* File: src/pmc_start_dly.sv */
// module: wake-up start delay counted in cpu clock cycles
module pmc_start_dly #(
   parameter int CYCLES = pmc_pkg::START_DELAY
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   pmc_clk_if.dly_mp c
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;
   logic busy_q;
   logic done_q;

   assign c.dly_busy = busy_q;
   assign c.dly_done = done_q;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (c.dly_start) begin
            cnt_q <= W'(CYCLES); // [R5] [R9]
            busy_q <= 1'b1;
         end else if (busy_q && c.tick) begin
            cnt_q <= cnt_q - W'(1);
            if (cnt_q == W'(1)) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_delay_end: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
      (busy_q && !c.dly_start && c.tick && cnt_q == W'(1)) |=> done_q && !busy_q)
      else $error("start delay did not end on last tick");
   a_done_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
      done_q |-> $past(busy_q) && $past(cnt_q) == W'(1))
      else $error("start delay ended early");
endmodule
